// ==== rtl/tfp_cap_if.sv ====
// Carrier between the timer core and its capture edge detector.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface tfp_cap_if #(
  parameter int N = 4
);
  logic [N-1:0] pin;
  logic [2*N-1:0] edge_sel;
  logic [N-1:0] edge_det;

  modport core (output pin, output edge_sel, input edge_det);
  modport det (input pin, input edge_sel, output edge_det);
endinterface

// ==== rtl/tfp_edge_det.sv ====
// Capture input synchroniser and selectable edge detector.
// Assumes pins are asynchronous-safe only after two flops.
`timescale 1ns/1ps
module tfp_edge_det #(
  parameter int N = 4
) (
  input wire logic clk_sys_in,
  input wire logic nrst_in,
  input wire logic clk_en_in,
  tfp_cap_if.det cap
);

  typedef struct packed {
    logic [N-1:0] sync1;
    logic [N-1:0] sync2;
    logic [N-1:0] prev;
    logic [N-1:0] det;
  } tfp_edge_s;

  tfp_edge_s s_r;
  tfp_edge_s s_nxt;
  logic [N-1:0] rise;
  logic [N-1:0] fall;
  logic [N-1:0] hit;

  ////////////////////////////////////////////////////////////////////////
  // Edges judged only on the second flop, never on the first
  assign rise = s_r.sync2 & ~s_r.prev;
  assign fall = ~s_r.sync2 & s_r.prev;

  for (genvar i = 0; i < N; i++) begin : g_sel
    logic [1:0] sel;
    assign sel = cap.edge_sel[2*i +: 2];
    // Code 00 disables the input
    assign hit[i] = ((sel == tfp_pkg::EDGE_RISE) && rise[i]) ||
                    ((sel == tfp_pkg::EDGE_FALL) && fall[i]) ||
                    ((sel == tfp_pkg::EDGE_BOTH) && (rise[i] || fall[i]));
  end

  always_comb begin
    s_nxt = s_r;
    s_nxt.sync1 = cap.pin;
    s_nxt.sync2 = s_r.sync1;
    s_nxt.prev = s_r.sync2;
    s_nxt.det = hit;
  end

  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      s_r <= '0;
    end else if (clk_en_in) begin
      s_r <= s_nxt;
    end
  end

  assign cap.edge_det = s_r.det;

endmodule

// ==== rtl/tfp_pkg.sv ====
// Shared constants and types of the free-running / pulse-width timer.
// Assumes a single system clock; all inputs but the capture pins are synchronous to it.
package tfp_pkg;

  localparam int CNT_W = 16;
  localparam int PRE_W = 7;
  localparam int CH_NUM = 6;
  localparam int CAP_NUM = 4;
  // Channels below this index can compare on the first instance
  localparam int FIRST_CMP_CH = 4;

  localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_MAX = 16'hFFFF;
  localparam logic [PRE_W-1:0] PRE_ZERO = 7'h00;

  // Operating mode select
  localparam logic [1:0] MODE_FREE = 2'h0;
  localparam logic [1:0] MODE_PWM = 2'h1;
  localparam logic [1:0] MODE_PULSE = 2'h2;

  // Capture edge select field codes
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;

  // Count clock select: system clock divided by 2**select
  localparam logic [2:0] CKS_DIV16 = 3'h4;

  typedef enum logic [1:0] {
    TFP_IDLE = 2'b01,
    TFP_RUN  = 2'b10
  } tfp_run_e;

endpackage

// ==== rtl/tfp_timer.sv ====
// 16-bit timer: free-running compare/capture, PWM reload, pulse width.
// Assumes software drives the control ports and that writes are pulses.
//
// Contract
// - PWM reload waits for a channel 1 write
// - PWM outputs 0 and 1 start high
// - Four-bit field picks compare, capture or mixed
// - Counter runs 0000 to FFFF, wraps, overflow interrupt
// - Free-running compare match interrupts, counter never cleared
// - Free-running compare writes take effect immediately
// - Toggle only when output enable is set
// - Outputs start high; toggle width value plus one
// - Capture edge copies counter, raises interrupt
// - Only one overflow indication between captures
// - Mixed mode: channel 1 compare, channel 0 dark
// - Slow clock capture before first tick reads FFFF
// - Edge codes 01 rise, 10 fall, 11 both
// - First instance compare 0-3, no capture
// - Inputs 0-3 capture same channel; 4,5 compare
// - Pulse mode captures channel 0, clears counter
// - Pulse mode inputs 1-3 capture channels 1-3
// - Pulse mode: capture and overflow interrupts only
// - Pulse width mode only on second instance
// - Overflow flag set on wrap, cleared by zero write
`timescale 1ns/1ps
module tfp_timer #(
  parameter bit IS_SECOND = 1'b1,
  parameter int NUM_CH = tfp_pkg::CH_NUM,
  parameter int NUM_CAP = tfp_pkg::CAP_NUM
) (
  input wire logic clk_sys_in,
  input wire logic nrst_in,
  input wire logic clk_en_in,
  input wire logic count_enable_bit_in,
  input wire logic [1:0] mode_sel_in,
  input wire logic [3:0] channel_function_select_in,
  input wire logic [2:0] count_clock_select_in,
  input wire logic [NUM_CH-1:0] output_enable_bit_in,
  input wire logic [NUM_CH-1:0] output_level_bit_in,
  input wire logic [2*NUM_CAP-1:0] capture_edge_select_in,
  input wire logic [NUM_CAP-1:0] capture_input_pin_in,
  input wire logic [NUM_CH-1:0] ccr_write_in,
  input wire logic [tfp_pkg::CNT_W-1:0] ccr_wdata_in,
  input wire logic overflow_flag_clear_in,
  output logic [NUM_CH-1:0][tfp_pkg::CNT_W-1:0] channel_compare_capture_out,
  output logic [tfp_pkg::CNT_W-1:0] count_out,
  output logic overflow_flag_out,
  output logic overflow_irq_out,
  output logic [NUM_CH-1:0] ch_match_capture_irq_out,
  output logic [NUM_CH-1:0] timer_output_pin_out
);

  localparam int W = tfp_pkg::CNT_W;

  typedef struct packed {
    tfp_pkg::tfp_run_e st;
    logic [tfp_pkg::PRE_W-1:0] pre;
    logic [W-1:0] cnt;
    logic [NUM_CH-1:0][W-1:0] ccr;
    logic [NUM_CH-1:0][W-1:0] buff;
    logic [NUM_CH-1:0] tout;
    logic [NUM_CH-1:0] pin;
    logic [NUM_CH-1:0] ch_irq;
    logic ovf;
    logic ovf_irq;
    logic first_pend;
    logic reload_arm;
  } tfp_state_s;

  tfp_state_s s_r;
  tfp_state_s s_nxt;

  ////////////////////////////////////////////////////////////////////////
  // Mode and channel function decode

  logic [1:0] mode;
  logic is_free;
  logic is_pwm;
  logic is_pulse;
  logic [NUM_CH-1:0] cap_fn;
  logic [NUM_CH-1:0] cmp_fn;
  logic [NUM_CAP-1:0] edge_det;
  logic [tfp_pkg::PRE_W-1:0] pre_last;
  logic tick;
  logic slow_clk;
  logic [W-1:0] cap_val;

  // A pulse request on the first instance falls back to free running
  assign mode = (mode_sel_in == tfp_pkg::MODE_PULSE && !IS_SECOND) ?
                tfp_pkg::MODE_FREE : mode_sel_in;
  assign is_free = (mode == tfp_pkg::MODE_FREE);
  assign is_pwm = (mode == tfp_pkg::MODE_PWM);
  assign is_pulse = (mode == tfp_pkg::MODE_PULSE);

  for (genvar c = 0; c < NUM_CH; c++) begin : g_fn
    if (c < NUM_CAP && c < 4) begin : g_cap
      // Code 10 is undefined and is treated as compare
      logic lo;
      logic hi;
      assign lo = channel_function_select_in[(c/2)*2];
      assign hi = channel_function_select_in[(c/2)*2+1];
      assign cap_fn[c] = IS_SECOND && (is_pulse ||
        (is_free && ((c % 2 == 0) ? lo : (lo && hi))));
    end else begin : g_cmp
      assign cap_fn[c] = 1'b0;
    end
    assign cmp_fn[c] = is_free && !cap_fn[c] &&
                       (IS_SECOND || c < tfp_pkg::FIRST_CMP_CH);
  end

  ////////////////////////////////////////////////////////////////////////
  // Count clock prescaler

  assign pre_last = tfp_pkg::PRE_W'((8'h01 << count_clock_select_in) -
                                    8'h01);
  assign tick = (s_r.pre == pre_last);
  assign slow_clk = (count_clock_select_in >= tfp_pkg::CKS_DIV16);
  // Before the first tick a slow clock has no valid count yet
  assign cap_val = (s_r.first_pend && slow_clk) ?
                   tfp_pkg::CNT_MAX : s_r.cnt;

  ////////////////////////////////////////////////////////////////////////
  // Capture edge detection

  tfp_cap_if #(.N(NUM_CAP)) cap_if ();

  assign cap_if.pin = capture_input_pin_in;
  assign cap_if.edge_sel = capture_edge_select_in;
  assign edge_det = cap_if.edge_det;

  tfp_edge_det #(.N(NUM_CAP)) u_edge (
    .clk_sys_in(clk_sys_in),
    .nrst_in(nrst_in),
    .clk_en_in(clk_en_in),
    .cap(cap_if.det)
  );

  ////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    s_nxt = s_r;
    s_nxt.ch_irq = '0;
    s_nxt.ovf_irq = 1'b0;
    for (int c = 0; c < NUM_CH; c++) begin
      if (ccr_write_in[c]) begin
        s_nxt.ccr[c] = ccr_wdata_in;
        // Outside PWM a write bypasses the reload buffer
        if (!is_pwm) begin
          s_nxt.buff[c] = ccr_wdata_in;
        end
      end
    end
    if (is_pwm && ccr_write_in[1]) begin
      s_nxt.reload_arm = 1'b1;
    end
    // Clear first so that a wrap in the same cycle still sets the flag
    if (overflow_flag_clear_in) begin
      s_nxt.ovf = 1'b0;
    end
    case (s_r.st)
      tfp_pkg::TFP_IDLE: begin
        if (count_enable_bit_in) begin
          s_nxt.st = tfp_pkg::TFP_RUN;
          s_nxt.cnt = tfp_pkg::CNT_ZERO;
          s_nxt.pre = tfp_pkg::PRE_ZERO;
          s_nxt.first_pend = 1'b1;
          s_nxt.tout = {NUM_CH{1'b1}};
        end
      end
      tfp_pkg::TFP_RUN: begin
        if (!count_enable_bit_in) begin
          s_nxt.st = tfp_pkg::TFP_IDLE;
        end else begin
          s_nxt.pre = tick ? tfp_pkg::PRE_ZERO :
                      tfp_pkg::PRE_W'(s_r.pre + 1'b1);
          if (tick) begin
            s_nxt.first_pend = 1'b0;
          end
          if (tick && is_pwm) begin
            for (int c = 1; c < NUM_CH; c++) begin
              if (s_r.cnt == s_r.buff[c]) begin
                s_nxt.ch_irq[c] = 1'b1;
                s_nxt.tout[c] = 1'b0;
              end
            end
            if (s_r.cnt == s_r.buff[0]) begin
              s_nxt.cnt = tfp_pkg::CNT_ZERO;
              s_nxt.ch_irq[0] = 1'b1;
              s_nxt.tout = {{(NUM_CH-1){1'b1}}, ~s_r.tout[0]};
              // Without a channel 1 write the buffers keep old values
              if (s_r.reload_arm) begin
                s_nxt.buff = s_r.ccr;
                s_nxt.reload_arm = 1'b0;
              end
            end else begin
              s_nxt.cnt = W'(s_r.cnt + 1'b1);
            end
          end else if (tick) begin
            s_nxt.cnt = W'(s_r.cnt + 1'b1);
            if (s_r.cnt == tfp_pkg::CNT_MAX) begin
              // One sticky bit: repeated wraps are not counted
              s_nxt.ovf = 1'b1;
              s_nxt.ovf_irq = 1'b1;
            end
            for (int c = 0; c < NUM_CH; c++) begin
              if (cmp_fn[c] && s_r.cnt == s_r.buff[c]) begin
                s_nxt.ch_irq[c] = 1'b1;
                if (output_enable_bit_in[c]) begin
                  s_nxt.tout[c] = ~s_r.tout[c];
                end
              end
            end
          end
          for (int c = 0; c < NUM_CAP; c++) begin
            if (cap_fn[c] && edge_det[c]) begin
              s_nxt.ccr[c] = cap_val;
              s_nxt.buff[c] = cap_val;
              s_nxt.ch_irq[c] = 1'b1;
            end
          end
          if (is_pulse && |(edge_det & cap_fn[NUM_CAP-1:0])) begin
            // Restart makes the next capture the pulse width
            s_nxt.cnt = tfp_pkg::CNT_ZERO;
            s_nxt.pre = tfp_pkg::PRE_ZERO;
          end
        end
      end
      default: begin
        s_nxt.st = tfp_pkg::TFP_IDLE;
      end
    endcase
    for (int c = 0; c < NUM_CH; c++) begin
      // Capture channels and pulse mode leave the pin inactive
      s_nxt.pin[c] = output_enable_bit_in[c] && !is_pulse &&
                     !cap_fn[c] &&
                     (s_nxt.tout[c] ^ output_level_bit_in[c]);
    end
  end

  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      s_r <= '0;
      s_r.st <= tfp_pkg::TFP_IDLE;
    end else if (clk_en_in) begin
      s_r <= s_nxt;
    end
  end

  assign channel_compare_capture_out = s_r.ccr;
  assign count_out = s_r.cnt;
  assign overflow_flag_out = s_r.ovf;
  assign overflow_irq_out = s_r.ovf_irq;
  assign ch_match_capture_irq_out = s_r.ch_irq;
  assign timer_output_pin_out = s_r.pin;

  ////////////////////////////////////////////////////////////////////////
  // Checks

  logic run;
  logic adv;
  assign run = (s_r.st == tfp_pkg::TFP_RUN) && count_enable_bit_in;
  assign adv = run && clk_en_in && tick;

  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!nrst_in);

  AST_OVF_SET: assert property (
    adv && !is_pwm && s_r.cnt == tfp_pkg::CNT_MAX && !(is_pulse &&
    |edge_det) |=> overflow_flag_out && overflow_irq_out && count_out == 0)
    else $error("overflow not flagged on wrap");

  AST_OVF_STICKY: assert property (
    clk_en_in && overflow_flag_out && !overflow_flag_clear_in
    |=> overflow_flag_out)
    else $error("overflow flag dropped without a clear");

  AST_OVF_IRQ_CAUSE: assert property (
    overflow_irq_out && $past(clk_en_in) |->
    $past(count_out) == tfp_pkg::CNT_MAX &&
    count_out == 0)
    else $error("overflow interrupt without wrap");

  AST_NO_CLEAR: assert property (
    adv && is_free && cmp_fn[1] && s_r.cnt == s_r.buff[1] &&
    s_r.cnt != tfp_pkg::CNT_MAX && !(|edge_det)
    |=> ch_match_capture_irq_out[1] && count_out == $past(count_out) + 1)
    else $error("compare match cleared the counter");

  AST_CAPTURE: assert property (
    run && clk_en_in && cap_fn[0] && edge_det[0] && !is_pulse &&
    !(s_r.first_pend && slow_clk)
    |=> channel_compare_capture_out[0] == $past(count_out) &&
    ch_match_capture_irq_out[0])
    else $error("capture value or interrupt wrong");

  AST_SLOW_FIRST: assert property (
    run && clk_en_in && cap_fn[0] && edge_det[0] && s_r.first_pend &&
    slow_clk |=> channel_compare_capture_out[0] == tfp_pkg::CNT_MAX)
    else $error("early capture on slow clock not FFFF");

  AST_PULSE_CLR: assert property (
    run && clk_en_in && is_pulse && edge_det[0] |=> count_out == 0)
    else $error("pulse mode did not clear counter");

  AST_PULSE_DARK: assert property (
    clk_en_in && is_pulse |=> timer_output_pin_out == '0)
    else $error("output driven in pulse mode");

  AST_MIX_CH0: assert property (
    clk_en_in && is_free && cap_fn[0] |=> !timer_output_pin_out[0])
    else $error("channel 0 output driven while capturing");

  AST_START_HIGH: assert property (
    clk_en_in && s_r.st == tfp_pkg::TFP_IDLE && count_enable_bit_in &&
    !is_pulse && output_enable_bit_in[1] && !output_level_bit_in[1] &&
    !cap_fn[1] |=> timer_output_pin_out[1])
    else $error("output not high at count start");

  AST_PWM_HOLD: assert property (
    adv && is_pwm && s_r.cnt == s_r.buff[0] && !s_r.reload_arm &&
    !ccr_write_in[1] |=> s_r.buff == $past(s_r.buff))
    else $error("PWM reload without channel 1 write");

  AST_PWM_RELOAD: assert property (
    adv && is_pwm && s_r.cnt == s_r.buff[0] && s_r.reload_arm
    |=> s_r.buff == $past(s_r.ccr))
    else $error("PWM reload missed after channel 1 write");

  AST_WRITE_NOW: assert property (
    clk_en_in && !is_pwm && ccr_write_in[1] && !(cap_fn[1] && edge_det[1])
    |=> s_r.buff[1] == $past(ccr_wdata_in))
    else $error("compare write not taken at once");

  AST_TOGGLE_GATE: assert property (
    adv && is_free && cmp_fn[0] && s_r.cnt == s_r.buff[0]
    |=> (s_r.tout[0] != $past(s_r.tout[0])) ==
    $past(output_enable_bit_in[0]))
    else $error("toggle does not follow output enable");

  COV_WRAP: cover property (overflow_irq_out);
  COV_CAPTURE: cover property (run && cap_fn[0] && edge_det[0]);
  COV_RELOAD: cover property (adv && is_pwm && s_r.reload_arm &&
                              s_r.cnt == s_r.buff[0]);
  COV_PULSE: cover property (run && is_pulse && edge_det[0]);

endmodule

// ==== verif/tfp_pin_model.sv ====
// Model of the external capture sources in front of the timer.
// Assumes the bench calls flip() just after a falling clock edge.
`timescale 1ns/1ps
module tfp_pin_model (
  input wire logic clk_sys_in,
  output logic [3:0] capture_input_pin_out
);
  ////////////////////////////////////////////////////////////////////////////
  // Pins idle low, so the detector's reset history sees no false edge
  initial begin
    capture_input_pin_out = 4'h0;
  end

  // No event clock pin is driven at all: counting stays internal
  // One clean level change per call, no bounce modelled
  task automatic flip(input int ch);
    capture_input_pin_out[ch] = ~capture_input_pin_out[ch];
  endtask
endmodule

// ==== verif/timer_free_run_pulse_measure_tb.sv ====
// Self-checking bench of the free-running / pulse-width timer.
// Assumes the second-instance build and a 250 MHz system clock.
`timescale 1ns/1ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin mismatches++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (a), (b)); end end
module timer_free_run_pulse_measure_tb;
  logic clk_sys_in = 1'b0;
  logic nrst_in = 1'b0;
  logic en = 1'b0;
  logic [1:0] mode = 2'h0;
  logic [3:0] fsel = 4'h0;
  logic [2:0] cks = 3'h0;
  logic [5:0] oe = 6'h00;
  logic [7:0] esel = 8'h00;
  logic [5:0] wr = 6'h00;
  logic [15:0] wdata = 16'h0000;
  logic ovf_clr = 1'b0;
  logic [3:0] pins;
  logic [5:0][15:0] ccr;
  logic [15:0] cnt;
  logic ovf_flag;
  logic ovf_irq;
  logic [5:0] irq;
  logic [5:0] tout;
  int mismatches = 0;
  int checks_done = 0;
  int cycles = 0;

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    forever #2 clk_sys_in = ~clk_sys_in;
  end

  tfp_timer i_tfp_timer (
    .clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .clk_en_in(1'b1),
    .count_enable_bit_in(en), .mode_sel_in(mode),
    .channel_function_select_in(fsel), .count_clock_select_in(cks),
    .output_enable_bit_in(oe), .output_level_bit_in(6'h00),
    .capture_edge_select_in(esel), .capture_input_pin_in(pins),
    .ccr_write_in(wr), .ccr_wdata_in(wdata),
    .overflow_flag_clear_in(ovf_clr),
    .channel_compare_capture_out(ccr), .count_out(cnt),
    .overflow_flag_out(ovf_flag), .overflow_irq_out(ovf_irq),
    .ch_match_capture_irq_out(irq), .timer_output_pin_out(tout)
  );

  tfp_pin_model i_tfp_pin_model (
    .clk_sys_in(clk_sys_in),
    .capture_input_pin_out(pins)
  );

  ////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Hang guard: whole run is about 70k cycles
  always @(posedge clk_sys_in) begin
    cycles++;
    if (cycles == 90000) begin
      mismatches++;
      give_verdict();
    end
  end

  task automatic tick(input int n);
    repeat (n) @(negedge clk_sys_in);
  endtask

  // Drop enable long enough to reach idle before changing the set-up
  task automatic start(input logic [1:0] m, input logic [3:0] f,
                       input logic [2:0] c, input logic [5:0] o);
    en = 1'b0;
    tick(2);
    mode = m;
    fsel = f;
    cks = c;
    oe = o;
    en = 1'b1;
  endtask

  task automatic wr_ccr(input int ch, input logic [15:0] v);
    wr[ch] = 1'b1;
    wdata = v;
    tick(1);
    wr = 6'h00;
    // Let an edge pass so back-to-back writes never share a time step
    tick(1);
  endtask

  task automatic wait_irq(input int ch, input int n);
    int i;
    i = 0;
    while (irq[ch] !== 1'b1 && i < n) begin
      tick(1);
      i++;
    end
    `CHK(irq[ch], 1'b1)
  endtask

  // Cycles from one change of an output pin to the next
  task automatic span(input int ch, output int w);
    logic l;
    l = tout[ch];
    w = 0;
    while (tout[ch] === l && w < 300) begin
      tick(1);
      w++;
    end
    l = tout[ch];
    w = 0;
    while (tout[ch] === l && w < 300) begin
      tick(1);
      w++;
    end
  endtask

  // Irq shows in the same cycle as the capture, which holds the count of the cycle before
  task automatic cap_edge(input int ch, input logic exp);
    logic seen;
    logic [15:0] prev;
    seen = 1'b0;
    prev = cnt;
    i_tfp_pin_model.flip(ch);
    repeat (6) begin
      tick(1);
      if (irq[ch] === 1'b1 && !seen) begin
        seen = 1'b1;
        `CHK(ccr[ch], prev)
      end
      prev = cnt;
    end
    `CHK(seen, exp)
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [15:0] v0, v1, a;
    int n, h, r, ch, d;
    void'($urandom(71084));
    tick(6);
    `CHK(cnt, 16'h0000)
    `CHK(ovf_flag, 1'b0)
    nrst_in = 1'b1;
    tick(1);
    // Compare: writes while stopped, toggle width, no clear on match
    v0 = 16'(5 + $urandom % 40);
    v1 = v0 + 16'(3 + $urandom % 20);
    wr_ccr(0, v0);
    wr_ccr(1, v1);
    start(tfp_pkg::MODE_FREE, 4'h0, 3'h0, 6'h01);
    n = 0;
    while (tout[0] !== 1'b1 && n < 8) begin
      tick(1);
      n++;
    end
    h = 0;
    while (tout[0] === 1'b1 && h < 200) begin
      tick(1);
      h++;
    end
    `CHK(h, int'(v0) + 1)
    `CHK(irq[0], 1'b1)
    `CHK(cnt, v0 + 16'h0001)
    `CHK(tout[1], 1'b0)
    wait_irq(1, 100);
    `CHK(cnt, v1 + 16'h0001)
    wr_ccr(1, v1 + 16'h001E);
    wait_irq(1, 40);
    `CHK(cnt, v1 + 16'h001F)
    // Mixed: channel 0 dark even though enabled
    start(tfp_pkg::MODE_FREE, 4'h1, 3'h0, 6'h03);
    tick(3);
    `CHK(tout[1:0], 2'h2)
    start(tfp_pkg::MODE_PWM, 4'h0, 3'h0, 6'h03);
    tick(3);
    `CHK(tout[1:0], 2'h3)
    // Cycle stays put until channel 1 is written, then reloads
    span(0, h);
    `CHK(h, int'(v0) + 1)
    wr_ccr(0, v0 + 16'h0004);
    span(0, h);
    `CHK(h, int'(v0) + 1)
    wr_ccr(1, v1);
    span(0, h);
    `CHK(h, int'(v0) + 5)
    // Capture: every edge code on some channel, order shuffled
    r = $urandom % 4;
    esel = {2'((r + 3) % 4), 2'((r + 2) % 4), 2'((r + 1) % 4), 2'(r % 4)};
    start(tfp_pkg::MODE_FREE, 4'hF, 3'h0, 6'h3F);
    tick(20);
    for (int i = 0; i < 4; i++) begin
      cap_edge(i, esel[2*i]);
      cap_edge(i, esel[2*i+1]);
    end
    `CHK(tout[3:0], 4'h0)
    // Slow clock: edge before the first tick
    esel = 8'h01;
    start(tfp_pkg::MODE_FREE, 4'h3, tfp_pkg::CKS_DIV16 + 3'h3, 6'h00);
    i_tfp_pin_model.flip(0);
    wait_irq(0, 8);
    `CHK(ccr[0], 16'hFFFF)
    i_tfp_pin_model.flip(0);
    // Pulse width: counter cleared per edge, so widths differ by 5
    esel = 8'hFF;
    start(tfp_pkg::MODE_PULSE, 4'hF, 3'h0, 6'h3F);
    tick(4);
    ch = $urandom % 4;
    d = 20 + $urandom % 20;
    i_tfp_pin_model.flip(ch);
    wait_irq(ch, 8);
    tick(d);
    i_tfp_pin_model.flip(ch);
    wait_irq(ch, 8);
    a = ccr[ch];
    tick(d + 5);
    i_tfp_pin_model.flip(ch);
    wait_irq(ch, 8);
    `CHK(16'(ccr[ch] - a), 16'h0005)
    `CHK(tout, 6'h00)
    `CHK(irq[5:4], 2'h0)
    // Overflow: wrap, sticky flag, cleared only by the clear pulse
    start(tfp_pkg::MODE_FREE, 4'h0, 3'h0, 6'h00);
    n = 0;
    while (ovf_irq !== 1'b1 && n < 66000) begin
      tick(1);
      n++;
    end
    `CHK(ovf_irq, 1'b1)
    `CHK(cnt, 16'h0000)
    `CHK(ovf_flag, 1'b1)
    tick(3);
    `CHK(ovf_flag, 1'b1)
    ovf_clr = 1'b1;
    tick(1);
    ovf_clr = 1'b0;
    tick(1);
    `CHK(ovf_flag, 1'b0)
    give_verdict();
  end
endmodule
